/* verilog/scsr_defs.vh */
`ifndef SCSR_DEFS_VH
`define SCSR_DEFS_VH

// ********************************************
// register offsets
// ********************************************
`define SCSR_OFS_MODE 4'h0
`define SCSR_OFS_CTL1 4'h1
`define SCSR_OFS_BR_LOW 4'h2
`define SCSR_OFS_BR_HIGH 4'h3
`define SCSR_OFS_STAT 4'h5
`define SCSR_OFS_RXBUF 4'h6
`define SCSR_OFS_TXBUF 4'h7
`define SCSR_OFS_IRQ_STAT 4'h8
`define SCSR_OFS_IRQ_EN 4'h9
`define SCSR_OFS_IRQ_CLR 4'hA

// ********************************************
// field positions
// ********************************************
`define SCSR_MODE_MASTER 0
`define SCSR_MODE_FOUR_WIRE 1
`define SCSR_CTL1_RST 0
`define SCSR_CTL1_SSEL_HI 7
`define SCSR_CTL1_SSEL_LO 6
`define SCSR_STAT_BUSY 0
`define SCSR_STAT_OE 5
`define SCSR_STAT_FE 6
`define SCSR_STAT_LISTEN 7
`define SCSR_IRQ_RX 0
`define SCSR_IRQ_OE 1
`define SCSR_IRQ_FE 2

// ********************************************
// reset values and codes
// ********************************************
`define SCSR_CTL1_RESET 8'h01
`define SCSR_BYTE_RESET 8'h00
`define SCSR_SSEL_AUX 2'h1
`define SCSR_BIT_LAST 3'h7
`define SCSR_DIV_MIN 16'h0002

`endif

/* verilog/scsr_prescaler.v */
`timescale 1ns/10ps
`default_nettype none
`include "scsr_defs.vh"

module scsr_prescaler (
  // clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // control
  input wire i_hold,
  input wire i_src_tick,
  input wire [15:0] i_divisor,
  // half-bit events
  output reg o_rise_tick,
  output reg o_fall_tick
);

  reg [15:0] count;
  wire [15:0] divisor;

  // values below two cannot give two clock edges per period
  assign divisor = (i_divisor < `SCSR_DIV_MIN) ? `SCSR_DIV_MIN : i_divisor;

  // ********************************************
  // divide source clock by prescaler
  // ********************************************
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= 16'h0000;
      o_rise_tick <= 1'b0;
      o_fall_tick <= 1'b0;
    end else if (i_hold) begin
      count <= 16'h0000;
      o_rise_tick <= 1'b0;
      o_fall_tick <= 1'b0;
    end else begin
      o_rise_tick <= i_src_tick && (count == 16'h0000);
      o_fall_tick <= i_src_tick && (count == {1'b0, divisor[15:1]});
      if (i_src_tick) begin
        if (count >= divisor - 16'h0001) begin
          count <= 16'h0000;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* verilog/scsr_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "scsr_defs.vh"

// How it works
// - master uses aux clock for 01, submain for 10/11; slave uses serial clock pin
// - master bit clock is the selected source divided by the prescaler
// - prescaler equals low byte plus high byte times 256
// - loopback bit feeds transmitter output back into the receiver
// - four-wire master sets bus conflict flag when slave-enable line is asserted
// - bus conflict flag never set in three-wire master or slave mode
// - overrun set on unread character overwrite, cleared by receive buffer read
module scsr_top (
  // clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // interrupt
  output reg o_irq,
  // bit rate source clocks
  input wire i_aux_clock,
  input wire i_submain_clock,
  // serial clock pin
  input wire i_serial_clock_pin,
  output reg o_serial_clock_pin,
  output reg o_serial_clock_oe,
  // slave enable line, active low
  input wire i_slave_enable_n,
  // data lines
  input wire i_mosi,
  output reg o_mosi,
  output reg o_mosi_oe,
  input wire i_miso,
  output reg o_miso,
  output reg o_miso_oe
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // ********************************************
  // registers and state
  // ********************************************
  reg [7:0] serial_mode;
  reg [7:0] serial_control_1;
  reg [7:0] bit_rate_low;
  reg [7:0] bit_rate_high;
  reg loopback_enable;
  reg bus_conflict_flag;
  reg overrun_flag;
  reg [7:0] receive_buffer;
  reg rx_unread;
  reg [7:0] tx_data;
  reg tx_pending;
  reg [2:0] irq_status;
  reg [2:0] irq_enable;
  reg state;
  reg [7:0] shreg;
  reg [2:0] bitcnt;
  reg tx_bit;
  reg aux_prev;
  reg submain_prev;
  reg pin_prev;

  reg next_rx_done;
  reg next_overrun;
  reg next_conflict;

  wire soft_reset_hold;
  wire master;
  wire four_wire;
  wire [1:0] clock_source_select;
  wire [15:0] bit_clock_prescaler;
  wire transfer_active;
  wire src_tick;
  wire m_rise;
  wire m_fall;
  wire slave_sel;
  wire rise_evt;
  wire fall_evt;
  wire rx_in;
  wire conflict;
  wire rd_rxbuf;
  wire wr_tx;
  wire [2:0] irq_clr;

  function hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign soft_reset_hold = serial_control_1[`SCSR_CTL1_RST];
  assign master = serial_mode[`SCSR_MODE_MASTER];
  assign four_wire = serial_mode[`SCSR_MODE_FOUR_WIRE];
  assign clock_source_select = serial_control_1[`SCSR_CTL1_SSEL_HI:`SCSR_CTL1_SSEL_LO];
  assign bit_clock_prescaler = {bit_rate_high, bit_rate_low};
  assign transfer_active = (state == ST_SHIFT);
  assign rd_rxbuf = i_rd && hit(i_addr, `SCSR_OFS_RXBUF);
  assign wr_tx = i_wr && hit(i_addr, `SCSR_OFS_TXBUF);
  assign irq_clr = (i_wr && hit(i_addr, `SCSR_OFS_IRQ_CLR)) ? i_wdata[2:0] : 3'h0;

  // ********************************************
  // clock source selection
  // ********************************************
  assign src_tick = (clock_source_select == `SCSR_SSEL_AUX) ? (i_aux_clock && !aux_prev) :
                    clock_source_select[1] ? (i_submain_clock && !submain_prev) : 1'b0;

  scsr_prescaler u_prescaler (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_hold(soft_reset_hold || !master || !transfer_active),
    .i_src_tick(src_tick),
    .i_divisor(bit_clock_prescaler),
    .o_rise_tick(m_rise),
    .o_fall_tick(m_fall)
  );

  // slave follows the serial clock pin in three-wire mode, or in four-wire mode while slave enable is low
  assign slave_sel = !four_wire || !i_slave_enable_n;
  assign rise_evt = master ? m_rise : (slave_sel && i_serial_clock_pin && !pin_prev);
  assign fall_evt = master ? m_fall : (slave_sel && !i_serial_clock_pin && pin_prev);

  // ********************************************
  // receive path and conflict detection
  // ********************************************
  assign rx_in = loopback_enable ? tx_bit : (master ? i_miso : i_mosi);
  assign conflict = master && four_wire && !i_slave_enable_n;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aux_prev <= 1'b0;
      submain_prev <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      aux_prev <= i_aux_clock;
      submain_prev <= i_submain_clock;
      pin_prev <= i_serial_clock_pin;
    end
  end

  // ********************************************
  // shift engine
  // ********************************************
  always @* begin
    next_rx_done = 1'b0;
    next_overrun = 1'b0;
    next_conflict = 1'b0;
    if (!soft_reset_hold) begin
      next_conflict = conflict;
      if (rise_evt && bitcnt == `SCSR_BIT_LAST && !conflict && (transfer_active || !master)) begin
        next_rx_done = 1'b1;
        next_overrun = rx_unread && !rd_rxbuf;
      end
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      shreg <= `SCSR_BYTE_RESET;
      bitcnt <= 3'h0;
      tx_bit <= 1'b0;
      tx_pending <= 1'b0;
      tx_data <= `SCSR_BYTE_RESET;
      o_serial_clock_pin <= 1'b0;
      o_mosi <= 1'b0;
      o_miso <= 1'b0;
      o_serial_clock_oe <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso_oe <= 1'b0;
    end else if (soft_reset_hold) begin
      state <= ST_IDLE;
      shreg <= `SCSR_BYTE_RESET;
      bitcnt <= 3'h0;
      tx_bit <= 1'b0;
      tx_pending <= 1'b0;
      o_serial_clock_pin <= 1'b0;
      o_mosi <= 1'b0;
      o_miso <= 1'b0;
      o_serial_clock_oe <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso_oe <= 1'b0;
      if (wr_tx) begin
        tx_data <= i_wdata;
      end
    end else begin
      o_serial_clock_oe <= master;
      o_mosi_oe <= master;
      o_miso_oe <= !master && slave_sel;
      if (wr_tx) begin
        tx_data <= i_wdata;
        tx_pending <= 1'b1;
      end
      if (conflict) begin
        state <= ST_IDLE;
        bitcnt <= 3'h0;
        o_serial_clock_pin <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (tx_pending && !wr_tx) begin
              shreg <= tx_data;
              tx_bit <= tx_data[7];
              o_mosi <= tx_data[7];
              o_miso <= tx_data[7];
              tx_pending <= 1'b0;
              bitcnt <= 3'h0;
              if (master) begin
                state <= ST_SHIFT;
              end
            end else if (!master && rise_evt) begin
              shreg <= {shreg[6:0], rx_in};
              bitcnt <= 3'h0;
              state <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (rise_evt) begin
              shreg <= {shreg[6:0], rx_in};
              o_serial_clock_pin <= master;
            end else if (fall_evt) begin
              o_serial_clock_pin <= 1'b0;
              tx_bit <= shreg[7];
              o_mosi <= shreg[7];
              o_miso <= shreg[7];
              if (bitcnt == `SCSR_BIT_LAST) begin
                state <= ST_IDLE;
                bitcnt <= 3'h0;
              end else begin
                bitcnt <= bitcnt + 3'h1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ********************************************
  // register writes and flags
  // ********************************************
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      serial_mode <= `SCSR_BYTE_RESET;
      serial_control_1 <= `SCSR_CTL1_RESET;
      bit_rate_low <= `SCSR_BYTE_RESET;
      bit_rate_high <= `SCSR_BYTE_RESET;
      loopback_enable <= 1'b0;
      bus_conflict_flag <= 1'b0;
      overrun_flag <= 1'b0;
      receive_buffer <= `SCSR_BYTE_RESET;
      rx_unread <= 1'b0;
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      if (i_wr && hit(i_addr, `SCSR_OFS_MODE)) begin
        serial_mode <= {6'h00, i_wdata[1:0]};
      end
      if (i_wr && hit(i_addr, `SCSR_OFS_CTL1)) begin
        serial_control_1 <= {i_wdata[7:6], 5'h00, i_wdata[0]};
      end
      if (i_wr && hit(i_addr, `SCSR_OFS_BR_LOW)) begin
        bit_rate_low <= i_wdata;
      end
      if (i_wr && hit(i_addr, `SCSR_OFS_BR_HIGH)) begin
        bit_rate_high <= i_wdata;
      end
      if (i_wr && hit(i_addr, `SCSR_OFS_STAT)) begin
        loopback_enable <= i_wdata[`SCSR_STAT_LISTEN];
      end
      if (i_wr && hit(i_addr, `SCSR_OFS_IRQ_EN)) begin
        irq_enable <= i_wdata[2:0];
      end
      // software may clear the conflict flag; a new conflict wins
      if (soft_reset_hold) begin
        bus_conflict_flag <= 1'b0;
      end else if (next_conflict) begin
        bus_conflict_flag <= 1'b1;
      end else if (i_wr && hit(i_addr, `SCSR_OFS_STAT) && !i_wdata[`SCSR_STAT_FE]) begin
        bus_conflict_flag <= 1'b0;
      end
      // overrun cleared by reading the receive buffer or by soft reset
      if (soft_reset_hold) begin
        overrun_flag <= 1'b0;
      end else if (next_overrun) begin
        overrun_flag <= 1'b1;
      end else if (rd_rxbuf) begin
        overrun_flag <= 1'b0;
      end
      if (soft_reset_hold) begin
        rx_unread <= 1'b0;
      end else if (next_rx_done) begin
        rx_unread <= 1'b1;
        receive_buffer <= {shreg[6:0], rx_in};
      end else if (rd_rxbuf) begin
        rx_unread <= 1'b0;
      end
      irq_status[`SCSR_IRQ_RX] <= next_rx_done || (irq_status[`SCSR_IRQ_RX] && !irq_clr[`SCSR_IRQ_RX]);
      irq_status[`SCSR_IRQ_OE] <= next_overrun || (irq_status[`SCSR_IRQ_OE] && !irq_clr[`SCSR_IRQ_OE]);
      irq_status[`SCSR_IRQ_FE] <= next_conflict || (irq_status[`SCSR_IRQ_FE] && !irq_clr[`SCSR_IRQ_FE]);
      o_irq <= |(irq_status & irq_enable);
    end
  end

  // ********************************************
  // register reads
  // ********************************************
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `SCSR_BYTE_RESET;
    end else if (i_rd) begin
      case (i_addr)
        `SCSR_OFS_MODE: o_rdata <= serial_mode;
        `SCSR_OFS_CTL1: o_rdata <= serial_control_1;
        `SCSR_OFS_BR_LOW: o_rdata <= bit_rate_low;
        `SCSR_OFS_BR_HIGH: o_rdata <= bit_rate_high;
        `SCSR_OFS_STAT: o_rdata <= {loopback_enable, bus_conflict_flag, overrun_flag, 4'h0, transfer_active};
        `SCSR_OFS_RXBUF: o_rdata <= receive_buffer;
        `SCSR_OFS_TXBUF: o_rdata <= tx_data;
        `SCSR_OFS_IRQ_STAT: o_rdata <= {5'h00, irq_status};
        `SCSR_OFS_IRQ_EN: o_rdata <= {5'h00, irq_enable};
        default: o_rdata <= `SCSR_BYTE_RESET;
      endcase
    end else begin
      o_rdata <= `SCSR_BYTE_RESET;
    end
  end

endmodule

`default_nettype wire

/* sim/scsr_top_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// port checks
// ****************
module scsr_top_chk (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // watched outputs
  input wire logic o_irq,
  input wire logic o_serial_clock_pin,
  input wire logic o_serial_clock_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  unmapped_zero_a: assert property (i_rd && (i_addr == 4'h4 || i_addr == 4'hA) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  oe_exclusive_a: assert property (o_mosi_oe |-> !o_miso_oe)
    else $error("master and slave drivers both on");
  slave_no_clk_a: assert property ((i_wr && i_addr == 4'h0 && !i_wdata[0]) ##1 !(i_wr && i_addr == 4'h0)
    |=> !o_serial_clock_oe)
    else $error("slave drives serial clock");
  clk_driven_a: assert property (o_serial_clock_pin |-> o_serial_clock_oe)
    else $error("serial clock high while not driven");
  hold_oe_a: assert property (i_wr && i_addr == 4'h1 && i_wdata[0] |-> ##2 !o_serial_clock_oe)
    else $error("clock driver on in soft reset");
  hold_clk_a: assert property (i_wr && i_addr == 4'h1 && i_wdata[0] |-> ##2 !o_serial_clock_pin [*3])
    else $error("serial clock runs in soft reset");
  ovr_clear_a: assert property ((i_rd && i_addr == 4'h6) ##1 (i_rd && i_addr == 4'h5) |=> !o_rdata[5])
    else $error("overrun not cleared by buffer read");
  irq_mask_a: assert property ((i_wr && i_addr == 4'h9 && i_wdata == 8'h00) ##1 !(i_wr && i_addr == 4'h9)
    |-> ##1 !o_irq)
    else $error("interrupt high with all enables off");
endmodule
bind scsr_top scsr_top_chk i_chk (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_irq(o_irq),
  .o_serial_clock_pin(o_serial_clock_pin),
  .o_serial_clock_oe(o_serial_clock_oe),
  .o_mosi_oe(o_mosi_oe),
  .o_miso_oe(o_miso_oe)
);
`default_nettype wire

/* sim/scsr_peer.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// serial slave peer
// ****************
module scsr_peer (
  // serial side
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  // bench side
  input wire logic i_load,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_got
);
  logic [7:0] sh = 8'h00;
  assign o_sdo = sh[7];
  // reload the reply byte on each load toggle
  always @(i_load) sh = i_tx;
  always @(posedge i_sclk) o_got = {o_got[6:0], i_sdi};
  // shifted-out bits show inverted junk, never a stale copy
  always @(negedge i_sclk) sh = {sh[6:0], ~sh[0]};
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
// ****************
// bench top
// ****************
module tb;
  logic i_ref_clk = 0;
  logic i_resetn = 0;
  logic i_wr = 0;
  logic i_rd = 0;
  logic i_aux_clock = 0;
  logic i_submain_clock = 0;
  logic i_slave_enable_n = 1;
  logic spin = 0;
  logic smosi = 0;
  logic [7:0] sgot = 0;
  logic ld = 0;
  logic [1:0] ac = 0;
  logic [3:0] i_addr = 0;
  logic [7:0] i_wdata = 0;
  logic [7:0] rd_v;
  logic [7:0] ptx = 0;
  logic [7:0] pgot;
  logic [7:0] o_rdata;
  logic o_irq, o_sclk, o_sclk_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, miso;
  int err_count = 0;
  int comparisons = 0;
  int sc = 0;
  int n, k, t0;
  logic [1:0] sl[3] = '{2'h1, 2'h2, 2'h3};
  int lo[3] = '{4, 2, 3};
  int hi[3] = '{0, 1, 0};
  int pr[3] = '{4, 6, 6};
  always #10 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    ac <= ac + 2'h1;
    i_aux_clock <= ac[1];
    sc <= (sc + 1) % 6;
    i_submain_clock <= (sc >= 3);
  end
  scsr_top i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_aux_clock(i_aux_clock),
    .i_submain_clock(i_submain_clock), .i_serial_clock_pin(spin), .o_serial_clock_pin(o_sclk),
    .o_serial_clock_oe(o_sclk_oe), .i_slave_enable_n(i_slave_enable_n), .i_mosi(smosi), .o_mosi(o_mosi),
    .o_mosi_oe(o_mosi_oe), .i_miso(miso), .o_miso(o_miso), .o_miso_oe(o_miso_oe));
  scsr_peer i_peer (.i_sclk(o_sclk), .i_sdi(o_mosi), .o_sdo(miso), .i_load(ld), .i_tx(ptx), .o_got(pgot));
  task wr(input logic [3:0] a, input logic [7:0] d);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 0;
    #1;
  endtask
  task rd(input logic [3:0] a);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 0;
    #1 rd_v = o_rdata;
  endtask
  task rc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_v, e)
  endtask
  task sw(input logic v);
    k = 0;
    while (o_sclk !== v && k < 5000) begin
      @(posedge i_ref_clk);
      #1 k++;
    end
    if (k == 5000) err_count++;
  endtask
  task idle;
    k = 0;
    @(posedge i_ref_clk);
    #1 rd(4'h5);
    while (rd_v[0] !== 1'b0 && k < 20000) begin
      rd(4'h5);
      k++;
    end
    if (k == 20000) err_count++;
  endtask
  task xfer(input logic [7:0] d, input logic [7:0] p);
    ptx = p;
    ld = ~ld;
    wr(4'h7, d);
    idle;
  endtask
  // external master: one byte on the serial clock pin, msb first
  task sbyte(input logic [7:0] d);
    for (int b = 7; b >= 0; b--) begin
      smosi <= d[b];
      repeat (2) @(posedge i_ref_clk);
      spin <= 1;
      sgot = {sgot[6:0], o_miso};
      repeat (2) @(posedge i_ref_clk);
      spin <= 0;
      @(posedge i_ref_clk);
    end
    #1;
  endtask
  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1;
    @(posedge i_ref_clk);
    #1 rc(4'h1, 8'h01);
    rc(4'h2, 8'h00);
    rc(4'h3, 8'h00);
    rc(4'h5, 8'h00);
    rc(4'h4, 8'h00);
    $display("test reset done");
    wr(4'h0, 8'h01);
    wr(4'h9, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, {sl[i], 6'h01});
      wr(4'h2, lo[i][7:0]);
      wr(4'h3, hi[i][7:0]);
      wr(4'h1, {sl[i], 6'h00});
      ptx = 8'h3C ^ i[7:0];
      ld = ~ld;
      wr(4'h7, 8'hA5 ^ i[7:0]);
      sw(1);
      sw(0);
      t0 = $time;
      sw(1);
      sw(0);
      n = ($time - t0) / 20;
      `CHK(n, (lo[i] + 256 * hi[i]) * pr[i])
      idle;
      `CHK(pgot, 8'hA5 ^ i[7:0])
      rc(4'h6, 8'h3C ^ i[7:0]);
      `CHK(o_irq, 1'b1)
      wr(4'hA, 8'h01);
      @(posedge i_ref_clk);
      #1 `CHK(o_irq, 1'b0)
    end
    $display("test rate done");
    xfer(8'h11, 8'h22);
    xfer(8'h33, 8'h44);
    rc(4'h5, 8'h20);
    rc(4'h6, 8'h44);
    rc(4'h5, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h07);
    $display("test overrun done");
    wr(4'h5, 8'h80);
    xfer(8'h5A, 8'hC3);
    rc(4'h6, 8'h5A);
    rc(4'h5, 8'h80);
    wr(4'h5, 8'h00);
    $display("test loopback done");
    i_slave_enable_n <= 0;
    wr(4'h0, 8'h03);
    xfer(8'h0F, 8'hF0);
    rc(4'h5, 8'h40);
    for (int m = 2; m >= 0; m--) begin
      wr(4'h1, 8'hC1);
      wr(4'h0, m[7:0]);
      wr(4'h1, 8'hC0);
      wr(4'h7, 8'h0F);
      repeat (300) @(posedge i_ref_clk);
      #1 rd(4'h5);
      `CHK(rd_v[6], 1'b0)
    end
    $display("test conflict done");
    wr(4'h7, 8'h96);
    sbyte(8'h69);
    `CHK(sgot, 8'h96)
    rc(4'h6, 8'h69);
    `CHK(o_miso_oe, 1'b1)
    `CHK(o_mosi_oe, 1'b0)
    `CHK(o_sclk_oe, 1'b0)
    $display("test slave done");
    end_sim;
  end
endmodule
`default_nettype wire
